/* pta_target.sv */
// Target agent that answers bus master transactions from a memory and I/O word
`timescale 1ns/10ps
`include "pta_map.svh"

// How it works
// - Answers addressed transactions, 32- or 64-bit path
// - Memory window on first BAR, I/O on second
// - Memory depth and hit range are parameters
// - Single 32-bit I/O data word behind BAR1
// - Any address in I/O window hits that word
// - Byte enables ignored; whole words always move
// - Retry input forces retry on memory transactions
// - Disconnect-with-data input ends memory after data
// - Disconnect-no-data input ends memory after one data phase, then stops with no data
// - Reset loads memory from image from offset zero
// - Locations beyond image are filled with zero
module pta_target #(
    parameter int MEM_LINES = 256,
    parameter logic [31:0] MEM_HIT_RANGE = 32'h0000_0400,
    parameter int INIT_LINES = 1,
    parameter logic [INIT_LINES*32-1:0] INIT_IMAGE = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pta_pkg::pta_bus_in_s bus_in,
    input wire logic force_retry_in,
    input wire logic force_disconnect_with_data_in,
    input wire logic force_disconnect_no_data_in,
    output pta_pkg::pta_bus_out_s bus_out,
    output logic [31:0] io_data_word,
    output logic init_done
);
    import pta_pkg::*;

    localparam int AW = $clog2(MEM_LINES);
    localparam logic [31:0] MEM_MASK = ~(MEM_HIT_RANGE - 32'h1);
    localparam logic [31:0] IO_MASK = ~(`PTA_IO_WINDOW - 32'h1);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic [31:0] mem [MEM_LINES];
    pta_state_e st, next_st;
    pta_term_e term, next_term;
    pta_space_e space, next_space;
    pta_bus_out_s next_bus_out;
    logic [31:0] addr, next_addr;
    logic [31:0] bar0, next_bar0;
    logic [31:0] bar1, next_bar1;
    logic [31:0] next_io_data_word;
    logic [AW-1:0] init_cnt, next_init_cnt;
    logic next_init_done;
    logic rd, next_rd;
    logic wide, next_wide;
    logic prev_frame_n, next_prev_frame_n;
    logic mem_we, mem_we_hi;
    logic [AW-1:0] mem_idx;

    // Word that a read returns for a given byte address
    function automatic logic [63:0] read_word(input pta_space_e sp,
                                              input logic [31:0] a,
                                              input logic [31:0] b0,
                                              input logic [31:0] b1,
                                              input logic [31:0] io);
        logic [AW-1:0] i;
        logic [63:0] w;
        i = a[AW+1:2];
        w = '0;
        unique case (sp)
            PTA_SP_MEM: w = {mem[AW'(i + AW'(1))], mem[i]};
            PTA_SP_IO: w = {32'h0, io};
            default: begin
                if (a[7:2] == `PTA_CFG_BAR0_IDX) begin
                    w = {32'h0, b0};
                end else if (a[7:2] == `PTA_CFG_BAR1_IDX) begin
                    w = {32'h0, b1};
                end
            end
        endcase
        return w;
    endfunction

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        logic addr_phase;
        logic is_mem_cmd;
        logic is_io_cmd;
        logic is_cfg_cmd;
        logic xfer;
        logic [31:0] step;
        addr_phase = !bus_in.frame_n && prev_frame_n;
        is_mem_cmd = (bus_in.cbe_n[3:0] == `PTA_CMD_MEM_RD) ||
                     (bus_in.cbe_n[3:0] == `PTA_CMD_MEM_WR) ||
                     (bus_in.cbe_n[3:0] == `PTA_CMD_MEM_RD_MULT) ||
                     (bus_in.cbe_n[3:0] == `PTA_CMD_MEM_RD_LINE) ||
                     (bus_in.cbe_n[3:0] == `PTA_CMD_MEM_WR_INV);
        is_io_cmd = (bus_in.cbe_n[3:0] == `PTA_CMD_IO_RD) ||
                    (bus_in.cbe_n[3:0] == `PTA_CMD_IO_WR);
        is_cfg_cmd = ((bus_in.cbe_n[3:0] == `PTA_CMD_CFG_RD) ||
                      (bus_in.cbe_n[3:0] == `PTA_CMD_CFG_WR)) &&
                     bus_in.idsel &&
                     (bus_in.ad_in[1:0] == `PTA_CFG_TYPE0);
        xfer = !bus_in.irdy_n && !bus_out.trdy_n;
        step = wide ? `PTA_QWORD_STEP : `PTA_WORD_STEP;
        next_st = st;
        next_term = term;
        next_space = space;
        next_bus_out = bus_out;
        next_addr = addr;
        next_bar0 = bar0;
        next_bar1 = bar1;
        next_io_data_word = io_data_word;
        next_init_cnt = init_cnt;
        next_init_done = init_done;
        next_rd = rd;
        next_wide = wide;
        next_prev_frame_n = bus_in.frame_n;
        mem_we = 1'b0;
        mem_we_hi = 1'b0;
        mem_idx = addr[AW+1:2];
        unique case (st)
            PTA_ST_INIT: begin
                mem_idx = init_cnt;
                mem_we = 1'b1;
                next_init_cnt = AW'(init_cnt + AW'(1));
                if (init_cnt == AW'(MEM_LINES - 1)) begin
                    next_init_done = 1'b1;
                    next_st = PTA_ST_IDLE;
                end
            end
            PTA_ST_IDLE: begin
                next_bus_out.ad_oe = 1'b0;
                next_bus_out.ctl_oe = 1'b0;
                if (addr_phase && (is_mem_cmd || is_io_cmd || is_cfg_cmd)) begin
                    next_addr = bus_in.ad_in[31:0];
                    next_rd = !bus_in.cbe_n[0];
                    next_term = PTA_TERM_NORMAL;
                    next_wide = 1'b0;
                    if (is_cfg_cmd) begin
                        next_space = PTA_SP_CFG;
                    end else if (is_io_cmd &&
                                 ((bus_in.ad_in[31:0] & IO_MASK) ==
                                  (bar1 & IO_MASK))) begin
                        next_space = PTA_SP_IO;
                    end else begin
                        next_space = PTA_SP_MEM;
                        next_wide = !bus_in.req64_n;
                        if (force_retry_in) begin
                            next_term = PTA_TERM_RETRY;
                        end else if (force_disconnect_no_data_in) begin
                            next_term = PTA_TERM_DISC_NODATA;
                        end else if (force_disconnect_with_data_in) begin
                            next_term = PTA_TERM_DISC_DATA;
                        end
                    end
                    if (is_cfg_cmd || (is_io_cmd &&
                        ((bus_in.ad_in[31:0] & IO_MASK) ==
                         (bar1 & IO_MASK))) || (is_mem_cmd &&
                        ((bus_in.ad_in[31:0] & MEM_MASK) == bar0))) begin
                        next_st = PTA_ST_WAIT;
                        next_bus_out.ctl_oe = 1'b1;
                        next_bus_out.devsel_n = 1'b0;
                        next_bus_out.ack64_n = !next_wide;
                        next_bus_out.ad_oe = !bus_in.cbe_n[0];
                    end
                end
            end
            PTA_ST_WAIT: begin
                next_st = PTA_ST_DATA;
                next_bus_out.ad_out = read_word(space, addr, bar0, bar1,
                                                io_data_word);
                if (term == PTA_TERM_RETRY) begin
                    next_bus_out.stop_n = 1'b0;
                end else begin
                    next_bus_out.trdy_n = 1'b0;
                    next_bus_out.stop_n = !(term == PTA_TERM_DISC_DATA);
                end
            end
            PTA_ST_DATA: begin
                if (xfer) begin
                    if (!rd) begin
                        unique case (space)
                            PTA_SP_MEM: begin
                                mem_we = 1'b1;
                                mem_we_hi = wide;
                            end
                            PTA_SP_IO: begin
                                next_io_data_word = bus_in.ad_in[31:0];
                            end
                            default: begin
                                if (addr[7:2] == `PTA_CFG_BAR0_IDX) begin
                                    next_bar0 = bus_in.ad_in[31:0] & MEM_MASK;
                                end else if (addr[7:2] == `PTA_CFG_BAR1_IDX) begin
                                    next_bar1 = (bus_in.ad_in[31:0] & IO_MASK) |
                                                `PTA_BAR1_SPACE;
                                end
                            end
                        endcase
                    end
                    next_addr = addr + step;
                    next_bus_out.ad_out = read_word(space, next_addr, bar0,
                                                    bar1, io_data_word);
                    if (bus_in.frame_n) begin
                        next_st = PTA_ST_TURN;
                        next_bus_out.trdy_n = 1'b1;
                        next_bus_out.devsel_n = 1'b1;
                        next_bus_out.stop_n = 1'b1;
                        next_bus_out.ack64_n = 1'b1;
                        next_bus_out.ad_oe = 1'b0;
                    end else if (term != PTA_TERM_NORMAL ||
                                 space != PTA_SP_MEM) begin
                        next_bus_out.trdy_n = 1'b1;
                        next_bus_out.stop_n = 1'b0;
                    end
                end else if (!bus_out.stop_n && bus_in.frame_n) begin
                    next_st = PTA_ST_TURN;
                    next_bus_out.trdy_n = 1'b1;
                    next_bus_out.devsel_n = 1'b1;
                    next_bus_out.stop_n = 1'b1;
                    next_bus_out.ack64_n = 1'b1;
                    next_bus_out.ad_oe = 1'b0;
                end
            end
            PTA_ST_TURN: begin
                next_st = PTA_ST_IDLE;
                next_bus_out.ctl_oe = 1'b0;
            end
            default: next_st = PTA_ST_IDLE;
        endcase
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= PTA_ST_INIT;
            term <= PTA_TERM_NORMAL;
            space <= PTA_SP_MEM;
            bus_out <= '{ad_out: '0, ad_oe: 1'b0, trdy_n: 1'b1,
                         devsel_n: 1'b1, stop_n: 1'b1, ack64_n: 1'b1,
                         ctl_oe: 1'b0};
            addr <= '0;
            bar0 <= `PTA_BAR0_RESET;
            bar1 <= `PTA_BAR1_RESET;
            io_data_word <= `PTA_IO_RESET;
            init_cnt <= '0;
            init_done <= 1'b0;
            rd <= 1'b0;
            wide <= 1'b0;
            prev_frame_n <= 1'b1;
        end else begin
            st <= next_st;
            term <= next_term;
            space <= next_space;
            bus_out <= next_bus_out;
            addr <= next_addr;
            bar0 <= next_bar0;
            bar1 <= next_bar1;
            io_data_word <= next_io_data_word;
            init_cnt <= next_init_cnt;
            init_done <= next_init_done;
            rd <= next_rd;
            wide <= next_wide;
            prev_frame_n <= next_prev_frame_n;
        end
    end

    // -------------------------------------------------------------------------
    // Memory array, filled from the image then written by the bus
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (st == PTA_ST_INIT) begin
            if (int'(init_cnt) < INIT_LINES) begin
                mem[init_cnt] <= INIT_IMAGE[int'(init_cnt)*32 +: 32];
            end else begin
                mem[init_cnt] <= `PTA_MEM_FILL;
            end
        end else begin
            if (mem_we) begin
                mem[mem_idx] <= bus_in.ad_in[31:0];
            end
            if (mem_we_hi) begin
                mem[AW'(mem_idx + AW'(1))] <= bus_in.ad_in[63:32];
            end
        end
    end

endmodule

/* pta_map.svh */
// Constant map of the target agent: commands, config offsets, windows, resets
`ifndef PTA_MAP_SVH
`define PTA_MAP_SVH

// -----------------------------------------------------------------------------
// Bus commands
// -----------------------------------------------------------------------------
`define PTA_CMD_IO_RD 4'h2
`define PTA_CMD_IO_WR 4'h3
`define PTA_CMD_MEM_RD 4'h6
`define PTA_CMD_MEM_WR 4'h7
`define PTA_CMD_CFG_RD 4'ha
`define PTA_CMD_CFG_WR 4'hb
`define PTA_CMD_MEM_RD_MULT 4'hc
`define PTA_CMD_MEM_RD_LINE 4'he
`define PTA_CMD_MEM_WR_INV 4'hf

// -----------------------------------------------------------------------------
// Configuration space and windows
// -----------------------------------------------------------------------------
`define PTA_CFG_BAR0_IDX 6'h04
`define PTA_CFG_BAR1_IDX 6'h05
`define PTA_CFG_TYPE0 2'h0
`define PTA_BAR0_RESET 32'h0000_0000
`define PTA_BAR1_RESET 32'h0000_0001
`define PTA_BAR1_SPACE 32'h0000_0001
`define PTA_IO_WINDOW 32'h0000_0010
`define PTA_IO_RESET 32'h0000_0000
`define PTA_MEM_FILL 32'h0000_0000
`define PTA_WORD_STEP 32'h0000_0004
`define PTA_QWORD_STEP 32'h0000_0008

`endif

/* pta_pkg.sv */
// Types of the target agent: states, terminations and pin carriers
package pta_pkg;

    typedef enum logic [2:0] {
        PTA_ST_INIT = 3'b000,
        PTA_ST_IDLE = 3'b001,
        PTA_ST_WAIT = 3'b010,
        PTA_ST_DATA = 3'b011,
        PTA_ST_TURN = 3'b100
    } pta_state_e;

    typedef enum logic [1:0] {
        PTA_TERM_NORMAL = 2'b00,
        PTA_TERM_RETRY = 2'b01,
        PTA_TERM_DISC_DATA = 2'b10,
        PTA_TERM_DISC_NODATA = 2'b11
    } pta_term_e;

    typedef enum logic [1:0] {
        PTA_SP_MEM = 2'b00,
        PTA_SP_IO = 2'b01,
        PTA_SP_CFG = 2'b10
    } pta_space_e;

    typedef struct packed {
        logic [63:0] ad_in;
        logic [7:0] cbe_n;
        logic frame_n;
        logic irdy_n;
        logic idsel;
        logic req64_n;
    } pta_bus_in_s;

    typedef struct packed {
        logic [63:0] ad_out;
        logic ad_oe;
        logic trdy_n;
        logic devsel_n;
        logic stop_n;
        logic ack64_n;
        logic ctl_oe;
    } pta_bus_out_s;

endpackage

/* pta_target_assertions.sv */
// Checker bound to the target agent, watching its pins
`timescale 1ns/10ps
module pta_target_checker #(
    parameter int MEM_LINES = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pta_pkg::pta_bus_in_s bus_in,
    input wire logic force_retry_in,
    input wire logic force_disconnect_with_data_in,
    input wire logic force_disconnect_no_data_in,
    input wire pta_pkg::pta_bus_out_s bus_out,
    input wire logic [31:0] io_data_word,
    input wire logic init_done
);
    import pta_pkg::*;
    // ------------------------------------------
    // Address phase, latched command, init count
    // ------------------------------------------
    logic prev_frame, next_prev_frame, start, mem, xfer;
    logic [3:0] cmd_q, next_cmd_q;
    logic [15:0] cnt, next_cnt;
    assign start = !bus_in.frame_n && prev_frame;
    assign mem = bus_in.cbe_n[2];
    assign xfer = !bus_in.irdy_n && !bus_out.trdy_n;
    always_comb begin
        next_prev_frame = bus_in.frame_n;
        next_cmd_q = start ? bus_in.cbe_n[3:0] : cmd_q;
        next_cnt = &cnt ? cnt : cnt + 16'h1;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_frame <= 1'b1;
            cmd_q <= 4'h0;
            cnt <= 16'h0;
        end else begin
            prev_frame <= next_prev_frame;
            cmd_q <= next_cmd_q;
            cnt <= next_cnt;
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_quiet;
        !init_done |-> bus_out.devsel_n && !bus_out.ctl_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("early claim");
    property p_init;
        $rose(init_done) |-> cnt == 16'(MEM_LINES);
    endproperty
    a_init: assert property (p_init) else $error("load time");
    property p_ack64;
        start && mem ##1 !bus_out.devsel_n
            |-> bus_out.ack64_n == $past(bus_in.req64_n);
    endproperty
    a_ack64: assert property (p_ack64) else $error("wide ack");
    property p_retry;
        start && mem && force_retry_in ##1 !bus_out.devsel_n
            |=> !bus_out.stop_n && bus_out.trdy_n;
    endproperty
    a_retry: assert property (p_retry) else $error("retry");
    property p_disc;
        start && mem && !force_retry_in && !force_disconnect_no_data_in
            && force_disconnect_with_data_in ##1 !bus_out.devsel_n
            |=> !bus_out.stop_n && !bus_out.trdy_n;
    endproperty
    a_disc: assert property (p_disc) else $error("disc data");
    property p_nodata;
        start && mem && !force_retry_in && force_disconnect_no_data_in
            ##1 !bus_out.devsel_n |=> !bus_out.trdy_n && bus_out.stop_n;
    endproperty
    a_nodata: assert property (p_nodata) else $error("no data");
    property p_plain;
        start && !mem ##1 !bus_out.devsel_n
            |=> !bus_out.trdy_n && bus_out.stop_n;
    endproperty
    a_plain: assert property (p_plain) else $error("io or cfg");
    property p_release;
        xfer && bus_in.frame_n |=> bus_out.trdy_n && bus_out.devsel_n
            && bus_out.stop_n && !bus_out.ad_oe ##1 !bus_out.ctl_oe;
    endproperty
    a_release: assert property (p_release) else $error("release");
    property p_io;
        xfer && cmd_q == 4'h3 |=> io_data_word == $past(bus_in.ad_in[31:0]);
    endproperty
    a_io: assert property (p_io) else $error("io word");
endmodule

bind pta_target pta_target_checker #(.MEM_LINES(MEM_LINES)) i_pta_target_checker (
    .sys_clk, .rst, .bus_in, .force_retry_in, .force_disconnect_with_data_in,
    .force_disconnect_no_data_in, .bus_out, .io_data_word, .init_done);

/* pta_master_model.sv */
// Bus master model that issues transactions to the target agent
`timescale 1ns/10ps
module pta_master_model (
    input wire logic sys_clk,
    input wire pta_pkg::pta_bus_out_s bus_out,
    output pta_pkg::pta_bus_in_s drv,
    output logic drv_oe,
    output logic done,
    output logic [10:0] res
);
    import pta_pkg::*;
    initial begin
        drv = {64'h0, 8'hff, 4'b1101};
        drv_oe = 1'b0;
        done = 1'b0;
        res = 11'h0;
    end
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
            input logic w64, input int n, input logic [31:0] wd);
        int k;
        int t;
        logic dv;
        logic st;
        logic sx;
        logic [31:0] b;
        k = 0;
        t = 0;
        {dv, st, sx} = 3'b000;
        drv.frame_n <= 1'b0;
        drv.ad_in <= {32'h0, addr};
        drv.cbe_n <= {4'h0, cmd};
        drv.req64_n <= !w64;
        drv_oe <= 1'b1;
        @(posedge sys_clk);
        drv.frame_n <= (n == 1);
        drv.irdy_n <= 1'b0;
        drv.cbe_n <= 8'($urandom);
        drv.ad_in <= {wd + 32'h1, wd};
        drv_oe <= cmd[0];
        while (t < 24) begin
            @(posedge sys_clk);
            t++;
            dv |= !bus_out.devsel_n;
            st |= !bus_out.stop_n;
            if (!bus_out.trdy_n) begin
                k++;
                sx |= !bus_out.stop_n;
                b = wd + 32'(k * (w64 ? 2 : 1));
                drv.ad_in <= {b + 32'h1, b};
            end
            // Last phase done, target stopped, or nobody claimed
            if (drv.frame_n && (!bus_out.trdy_n || !bus_out.stop_n
                    || (t > 4 && !dv))) break;
            if (!bus_out.stop_n || k >= n - 1 || (t > 3 && !dv)) begin
                drv.frame_n <= 1'b1;
            end
        end
        drv.irdy_n <= 1'b1;
        drv.req64_n <= 1'b1;
        drv_oe <= 1'b0;
        @(posedge sys_clk);
        res <= {dv, st, sx, 8'(k)};
        done <= 1'b1;
        @(posedge sys_clk);
        done <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

/* test_pci_target_agent_model.sv */
// Self-checking bench for the target agent with a bus master model
`timescale 1ns/10ps
`include "pta_map.svh"
module test_pci_target_agent_model;
    import pta_pkg::*;
    localparam logic [31:0] IMG0 = 32'h5a5a_0001;
    localparam logic [31:0] IMG1 = 32'ha5a5_0002;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic force_retry_in = 1'b0;
    logic force_disconnect_with_data_in = 1'b0;
    logic force_disconnect_no_data_in = 1'b0;
    logic drv_oe, done, init_done;
    logic [10:0] res;
    logic [63:0] ad_w, rd_w;
    logic [31:0] io_data_word;
    pta_bus_in_s bus_in, drv;
    pta_bus_out_s bus_out;
    logic [31:0] mem_m [16];
    logic [31:0] io_m = 32'h0;
    logic [63:0] exp_data [$];
    logic [63:0] exp_end [$];
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    // Weak pull-up when nobody drives the address/data lines
    assign ad_w = bus_out.ad_oe ? bus_out.ad_out : drv_oe ? drv.ad_in : '1;
    assign bus_in = {ad_w, drv.cbe_n, drv.frame_n, drv.irdy_n, ad_w[16],
        drv.req64_n};
    assign rd_w = bus_out.ack64_n ? {32'h0, bus_out.ad_out[31:0]} : bus_out.ad_out;
    pta_target #(.MEM_LINES(16), .MEM_HIT_RANGE(32'h0000_0040), .INIT_LINES(2),
        .INIT_IMAGE({IMG1, IMG0})) i_pta_target (.sys_clk(sys_clk), .rst(rst),
        .bus_in(bus_in), .force_retry_in(force_retry_in),
        .force_disconnect_with_data_in(force_disconnect_with_data_in),
        .force_disconnect_no_data_in(force_disconnect_no_data_in),
        .bus_out(bus_out), .io_data_word(io_data_word), .init_done(init_done));
    pta_master_model i_pta_master_model (.sys_clk(sys_clk), .bus_out(bus_out),
        .drv(drv), .drv_oe(drv_oe), .done(done), .res(res));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run(input logic [3:0] cmd, input logic [31:0] addr,
            input logic w64, input int n, input logic [2:0] f,
            input logic [31:0] wd);
        logic mem, dv, st, sx;
        int k;
        int s;
        logic [3:0] ix;
        mem = cmd[2];
        s = w64 ? 2 : 1;
        dv = mem ? addr[31:6] == 26'h40 : cmd[3] ? addr[16] : addr[31:4] == 28'h200;
        k = dv ? n : 0;
        st = 1'b0;
        sx = 1'b0;
        if (dv && mem && f[2]) begin
            k = 0;
            st = 1'b1;
        end else if (dv && mem && f[1]) begin
            k = 1;
            st = n > 1;
        end else if (dv && mem && f[0]) begin
            k = 1;
            st = 1'b1;
            sx = 1'b1;
        end
        for (int i = 0; i < k * s; i++) begin
            ix = addr[5:2] + 4'(i);
            if (mem && cmd[0]) mem_m[ix] = wd + 32'(i);
            if (!mem && !cmd[3] && cmd[0]) io_m = wd;
            if (!cmd[0] && i % s == 0) exp_data.push_back(
                {w64 ? mem_m[ix + 4'h1] : 32'h0,
                 mem ? mem_m[ix] : cmd[3] ? wd : io_m});
        end
        exp_end.push_back(64'({dv, st, sx, 8'(k)}));
        force_retry_in <= f[2];
        force_disconnect_no_data_in <= f[1];
        force_disconnect_with_data_in <= f[0];
        i_pta_master_model.xfer(cmd, addr, w64, n, wd);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
        if (bus_out.ad_oe === 1'b1 && bus_out.trdy_n === 1'b0
                && bus_in.irdy_n === 1'b0) begin
            check(rd_w, exp_data.pop_front());
        end
        if (done === 1'b1) check(64'(res), exp_end.pop_front());
    end
    initial begin
        void'($urandom(32'hee91));
        foreach (mem_m[i]) mem_m[i] = 32'h0;
        mem_m[0] = IMG0;
        mem_m[1] = IMG1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check({32'h0, io_data_word}, 64'h0);
        check({63'h0, init_done}, 64'h0);
        while (init_done !== 1'b1 && cyc < 200) @(posedge sys_clk);
        run(`PTA_CMD_CFG_WR, 32'h0001_0010, 1'b0, 1, 3'h0, 32'h1000);
        run(`PTA_CMD_CFG_WR, 32'h0001_0014, 1'b0, 1, 3'h0, 32'h2001);
        run(`PTA_CMD_CFG_RD, 32'h0001_0010, 1'b0, 1, 3'h4, 32'h1000);
        run(`PTA_CMD_CFG_RD, 32'h0001_0014, 1'b0, 1, 3'h7, 32'h2001);
        run(`PTA_CMD_MEM_RD, 32'h1000, 1'b0, 4, 3'h0, 32'h0);
        run(`PTA_CMD_MEM_WR, 32'h1038, 1'b0, 4, 3'h0, $urandom);
        run(`PTA_CMD_MEM_RD_MULT, 32'h1038, 1'b1, 2, 3'h0, 32'h0);
        run(`PTA_CMD_MEM_WR_INV, 32'h1008, 1'b1, 2, 3'h0, $urandom);
        run(`PTA_CMD_MEM_RD_LINE, 32'h1000, 1'b0, 6, 3'h0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            run(`PTA_CMD_MEM_WR, 32'h1010, 1'b0, 3, 3'(i), $urandom);
            run(`PTA_CMD_MEM_RD, 32'h1010, 1'b0, 3, 3'(i), 32'h0);
            run(`PTA_CMD_IO_WR, 32'h2000 + 32'($urandom % 16), 1'b0, 1, 3'(i),
                $urandom);
            run(`PTA_CMD_IO_RD, 32'h2000 + 32'($urandom % 16), 1'b0, 1, 3'(i),
                32'h0);
        end
        run(`PTA_CMD_MEM_RD, 32'h1040, 1'b0, 1, 3'h0, 32'h0);
        run(`PTA_CMD_IO_RD, 32'h2010, 1'b0, 1, 3'h0, 32'h0);
        run(`PTA_CMD_CFG_RD, 32'h0000_0010, 1'b0, 1, 3'h0, 32'h0);
        // Every expected read word and every ending must have been seen
        check(64'(exp_data.size()), 64'h0);
        check(64'(exp_end.size()), 64'h0);
        tally_and_finish();
    end
endmodule
